// ===== dct_consts.vh
// Constants for the counter pair control block: register offsets,
// field positions and reset values. Assumes the includer is a module.
`ifndef DCT_CONSTS_VH
`define DCT_CONSTS_VH
`define DCT_ADDR_MODE 8'h01
`define DCT_ADDR_CBCTL 8'h02
`define DCT_ADDR_RUNSYNC 8'h03
`define DCT_ADDR_CAPLO 8'h04
`define DCT_ADDR_CAPHI 8'h05
// Shared mode control fields
`define DCT_MODE_INSEL 7
`define DCT_MODE_DEMOD 6
`define DCT_MODE_EDGE_HI 5
`define DCT_MODE_EDGE_LO 4
`define DCT_MODE_FLT_HI 3
`define DCT_MODE_FLT_LO 2
// Counter B control fields
`define DCT_CB_EN 7
`define DCT_CB_POLICY 6
`define DCT_CB_TMO 5
`define DCT_CB_CLK_HI 4
`define DCT_CB_CLK_LO 3
`define DCT_CB_CAPMSK 2
`define DCT_CB_CNTMSK 1
`define DCT_CB_OUTSEL 0
// Run and sync register fields
`define DCT_RS_BEN 7
`define DCT_RS_AEN 6
`define DCT_RS_SYNC 5
`define DCT_RS_RSVD 5'h1f
// Reset values and counts
`define DCT_MODE_RST 8'h00
`define DCT_CB_RST 8'h00
`define DCT_A_RELOAD 8'hff
`define DCT_B_RELOAD 16'hffff
`define DCT_DIV_W 3
`endif

// ===== dct_input_filter.v
// Input circuit: pin synchroniser, glitch filter and edge detector.
// Assumes both pins are asynchronous to clk_i.
`timescale 1ns/100ps
module dct_input_filter (
  input wire clk_i,
  input wire rst_n_i,
  input wire pin_a_i,
  input wire pin_b_i,
  input wire sel_b_i,
  input wire [1:0] edge_sel_i,
  input wire [1:0] flt_sel_i,
  output reg pos_o,
  output reg neg_o
);
  reg [1:0] sa_r;
  reg [1:0] sb_r;
  reg flt_r;
  reg [3:0] cnt_r;
  reg [3:0] need;
  wire raw;

  // Second stage only is read, the first feeds nothing else
  assign raw = sel_b_i ? sb_r[1] : sa_r[1];

  always @* begin
    case (flt_sel_i)
      2'd0: need = 4'h0;
      2'd1: need = 4'h1;
      2'd2: need = 4'h3;
      default: need = 4'h7;
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sa_r <= 2'b00;
      sb_r <= 2'b00;
      flt_r <= 1'b0;
      cnt_r <= 4'h0;
      pos_o <= 1'b0;
      neg_o <= 1'b0;
    end else begin
      sa_r <= {sa_r[0], pin_a_i};
      sb_r <= {sb_r[0], pin_b_i};
      pos_o <= 1'b0;
      neg_o <= 1'b0;
      if (raw == flt_r) begin
        cnt_r <= 4'h0;
      end else if (cnt_r >= need) begin
        // Level held long enough: accept it as a real edge
        flt_r <= raw;
        cnt_r <= 4'h0;
        pos_o <= raw & edge_sel_i[0];
        neg_o <= ~raw & edge_sel_i[1];
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule // dct_input_filter

// ===== dct_counter_pair.v
// Control and status for the counter pair: registers, counter B
// demodulation capture, timeout flag, interrupt requests and pin route.
// Assumes a register port from the core on the same clock as clk_i.
//
// Overview of operation
// - Policy 0: capture and reload each edge
// - Policy 1: capture first edge, ignore later
// - Terminal count sets timeout; write 1 clears
// - Capture with mask raises capture interrupt
// - Timeout with mask raises counter interrupt
// - Select bit routes pin: port or waveform
// - Clock-select field sets counter B rate
// - Bit 7 runs/stops counter B, reads status
// - Bit 6 runs/stops counter A, reads status
// - Bit 5 is sync-mode enable, reset 0
// - Stop-mode recovery keeps sync bit
// - Bits 4..0 read ones, writes ignored
// - Edge detector on selected pin, edges chosen
// - Filter drops pulses below selected width
// - Sync aligns counter A with demodulated edge
`timescale 1ns/100ps
`include "dct_consts.vh"
module dct_counter_pair (
  input wire clk_i,
  input wire rst_n_i,
  input wire stop_recover_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire capture_input_pin_a_i,
  input wire capture_input_pin_b_i,
  input wire port_out_i,
  output reg [7:0] reg_rdata_o,
  output reg counter_b_output_pin_o,
  output reg capture_irq_o,
  output reg timeout_irq_o,
  output reg counter_a_timeout_o
);
  reg [7:0] mode_r;
  reg [7:0] cb_ctl_r;
  reg b_run_r;
  reg a_run_r;
  reg sync_r;
  reg tmo_r;
  reg [15:0] cnt_b_r;
  reg [7:0] cnt_a_r;
  reg [15:0] cap_r;
  reg armed_r;
  reg wave_r;
  reg [`DCT_DIV_W-1:0] div_r;
  reg [7:0] rd_nxt;
  reg tick;
  wire pos_edge;
  wire neg_edge;
  wire any_edge;
  wire demod;
  wire wr_mode;
  wire wr_cb;
  wire wr_rs;
  wire b_zero;
  wire a_zero;
  wire b_tc;
  wire a_tc;
  wire edge_cap;
  wire tmo_cap;
  wire capture;
  wire rearm;

  function sel_hit;
    input [7:0] addr;
    input [7:0] want;
    input strobe;
    begin
      sel_hit = strobe & (addr == want);
    end
  endfunction

  assign wr_mode = sel_hit(reg_addr_i, `DCT_ADDR_MODE, reg_wr_i);
  assign wr_cb = sel_hit(reg_addr_i, `DCT_ADDR_CBCTL, reg_wr_i);
  assign wr_rs = sel_hit(reg_addr_i, `DCT_ADDR_RUNSYNC, reg_wr_i);

  dct_input_filter u_filt (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_a_i(capture_input_pin_a_i),
    .pin_b_i(capture_input_pin_b_i),
    .sel_b_i(mode_r[`DCT_MODE_INSEL]),
    .edge_sel_i(mode_r[`DCT_MODE_EDGE_HI:`DCT_MODE_EDGE_LO]),
    .flt_sel_i(mode_r[`DCT_MODE_FLT_HI:`DCT_MODE_FLT_LO]),
    .pos_o(pos_edge),
    .neg_o(neg_edge)
  );

  assign any_edge = pos_edge | neg_edge;
  assign demod = mode_r[`DCT_MODE_DEMOD];

  // Prescaler: field 0..3 gives divide by 1, 2, 4 or 8
  always @* begin
    case (cb_ctl_r[`DCT_CB_CLK_HI:`DCT_CB_CLK_LO])
      2'd0: tick = 1'b1;
      2'd1: tick = (div_r[0] == 1'b1);
      2'd2: tick = (div_r[1:0] == 2'b11);
      default: tick = (div_r == 3'b111);
    endcase
  end

  assign b_zero = (cnt_b_r == 16'h0000);
  assign a_zero = (cnt_a_r == 8'h00);
  assign b_tc = b_run_r & tick & b_zero;
  assign a_tc = a_run_r & a_zero;

  // Policy 0 captures every edge; policy 1 only while armed
  assign edge_cap = b_run_r & demod & any_edge &
    (~cb_ctl_r[`DCT_CB_POLICY] | armed_r);
  // Under policy 1, once disarmed, a counter A timeout also captures, without reload
  assign tmo_cap = b_run_r & demod & cb_ctl_r[`DCT_CB_POLICY] &
    ~armed_r & a_tc;
  assign capture = edge_cap | tmo_cap;
  // Writing the policy bit 0 then 1 arms it again for one edge
  assign rearm = wr_cb & reg_wdata_i[`DCT_CB_POLICY] &
    ~cb_ctl_r[`DCT_CB_POLICY];

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_r <= 1'b0;
    end else if (wr_rs) begin
      sync_r <= reg_wdata_i[`DCT_RS_SYNC];
    end
  end

  // Stop-mode recovery reinitialises all state except the sync bit, the read data register and the input filter
  always @(posedge clk_i) begin
    if (!rst_n_i || stop_recover_i) begin
      mode_r <= `DCT_MODE_RST;
      cb_ctl_r <= `DCT_CB_RST;
      b_run_r <= 1'b0;
      a_run_r <= 1'b0;
      tmo_r <= 1'b0;
      cnt_b_r <= `DCT_B_RELOAD;
      cnt_a_r <= `DCT_A_RELOAD;
      cap_r <= 16'h0000;
      armed_r <= 1'b1;
      wave_r <= 1'b0;
      div_r <= {`DCT_DIV_W{1'b0}};
      capture_irq_o <= 1'b0;
      timeout_irq_o <= 1'b0;
      counter_a_timeout_o <= 1'b0;
      counter_b_output_pin_o <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_r <= reg_wdata_i;
      end
      if (wr_cb) begin
        cb_ctl_r <= reg_wdata_i;
      end
      // Run/sync enable bits start or stop both counters; counter B control bit 7 only counter B
      if (wr_rs) begin
        b_run_r <= reg_wdata_i[`DCT_RS_BEN];
        a_run_r <= reg_wdata_i[`DCT_RS_AEN];
      end else if (wr_cb) begin
        b_run_r <= reg_wdata_i[`DCT_CB_EN];
      end
      div_r <= div_r + 3'd1;
      // Set wins over a clear in the same cycle
      if (b_tc) begin
        tmo_r <= 1'b1;
      end else if (wr_cb && reg_wdata_i[`DCT_CB_TMO]) begin
        tmo_r <= 1'b0;
      end
      if (rearm) begin
        armed_r <= 1'b1;
      end else if (edge_cap) begin
        armed_r <= 1'b0;
      end
      if (capture) begin
        cap_r <= cnt_b_r;
      end
      if (edge_cap) begin
        cnt_b_r <= `DCT_B_RELOAD;
      end else if (b_run_r && tick) begin
        // Counts on past zero by wrapping back to the reload value
        cnt_b_r <= cnt_b_r - 16'h0001;
      end
      if (b_tc) begin
        wave_r <= ~wave_r;
      end
      // Sync: counter A restarts with the demodulated edge so the
      // first carrier pulse is always whole
      if (sync_r && edge_cap) begin
        cnt_a_r <= `DCT_A_RELOAD;
      end else if (a_run_r) begin
        cnt_a_r <= cnt_a_r - 8'h01;
      end
      capture_irq_o <= capture & cb_ctl_r[`DCT_CB_CAPMSK];
      timeout_irq_o <= b_tc & cb_ctl_r[`DCT_CB_CNTMSK];
      counter_a_timeout_o <= a_tc;
      counter_b_output_pin_o <= cb_ctl_r[`DCT_CB_OUTSEL] ?
        wave_r : port_out_i;
    end
  end

  always @* begin
    case (reg_addr_i)
      `DCT_ADDR_MODE: rd_nxt = mode_r;
      `DCT_ADDR_CBCTL: rd_nxt = {b_run_r, cb_ctl_r[6],
        tmo_r, cb_ctl_r[4:0]};
      `DCT_ADDR_RUNSYNC: rd_nxt = {b_run_r, a_run_r, sync_r,
        `DCT_RS_RSVD};
      `DCT_ADDR_CAPLO: rd_nxt = cap_r[7:0];
      `DCT_ADDR_CAPHI: rd_nxt = cap_r[15:8];
      default: rd_nxt = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_nxt;
    end
  end
endmodule // dct_counter_pair

// ===== dct_cp_assertions.sv
// Port checker for the counter pair control block.
// Bound to dct_counter_pair; one clock, synchronous low reset.
`timescale 1ns/100ps
module dct_cp_assertions (
  input wire clk_i,
  input wire rst_n_i,
  input wire stop_recover_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire port_out_i,
  input wire [7:0] reg_rdata_o,
  input wire counter_b_output_pin_o,
  input wire capture_irq_o,
  input wire timeout_irq_o
);
  reg [7:5] rs_r;
  reg [2:0] cb_r;
  wire rd3 = reg_rd_i && reg_addr_i == 8'h03;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Shadows; stop recovery spares the sync bit
  always @(posedge clk_i) begin
    if (!rst_n_i || stop_recover_i) begin
      rs_r[7:6] <= 2'h0;
      cb_r <= 3'h0;
    end else if (reg_wr_i && reg_addr_i == 8'h03) begin
      rs_r <= reg_wdata_i[7:5];
    end else if (reg_wr_i && reg_addr_i == 8'h02) begin
      cb_r <= reg_wdata_i[2:0];
      // Counter B control bit 7 also starts or stops counter B
      rs_r[7] <= reg_wdata_i[7];
    end
    if (!rst_n_i) begin
      rs_r[5] <= 1'b0;
    end
  end
  property p_rsvd; rd3 |=> reg_rdata_o[4:0] == 5'h1f; endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits");
  property p_ben; rd3 |=> reg_rdata_o[7] == $past(rs_r[7]); endproperty
  a_ben: assert property (p_ben)
    else $error("b run bit");
  property p_aen; rd3 |=> reg_rdata_o[6] == $past(rs_r[6]); endproperty
  a_aen: assert property (p_aen)
    else $error("a run bit");
  property p_sync; rd3 |=> reg_rdata_o[5] == $past(rs_r[5]); endproperty
  a_sync: assert property (p_sync)
    else $error("sync bit");
  property p_keep;
    stop_recover_i ##2 rd3 |=> reg_rdata_o[7:5] == {2'b00, rs_r[5]};
  endproperty
  a_keep: assert property (p_keep)
    else $error("stop recovery bits");
  property p_route;
    !cb_r[0] && !reg_wr_i |=> counter_b_output_pin_o == $past(port_out_i);
  endproperty
  a_route: assert property (p_route)
    else $error("pin route");
  property p_cap; capture_irq_o |-> cb_r[2] ##1 !capture_irq_o; endproperty
  a_cap: assert property (p_cap)
    else $error("capture irq");
  property p_tmo; timeout_irq_o |-> cb_r[1] ##1 !timeout_irq_o; endproperty
  a_tmo: assert property (p_tmo)
    else $error("timeout irq");
  c_cap: cover property (capture_irq_o);
  c_tmo: cover property (timeout_irq_o);
  c_keep: cover property (stop_recover_i ##2 rd3);
endmodule // dct_cp_assertions
bind dct_counter_pair dct_cp_assertions dct_cp_assertions_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .stop_recover_i(stop_recover_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .port_out_i(port_out_i), .reg_rdata_o(reg_rdata_o),
  .counter_b_output_pin_o(counter_b_output_pin_o),
  .capture_irq_o(capture_irq_o), .timeout_irq_o(timeout_irq_o));

// ===== dct_core_model.sv
// Core-side model: register strobes toward the counter pair.
// Assumes one caller at a time, all timing on clk_i.
`timescale 1ns/100ps
module dct_core_model (
  input wire clk_i,
  input wire [7:0] rdata_i,
  output reg [7:0] addr_o = 8'h00,
  output reg [7:0] wdata_o = 8'h00,
  output reg wr_o = 1'b0,
  output reg rd_o = 1'b0
);
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      @(posedge clk_i);
      #1 d = rdata_i;
    end
  endtask
endmodule // dct_core_model

// ===== tb.sv
// Self-checking bench for the counter pair control block.
// Assumes the core model and the bound checker compile first.
`timescale 1ns/100ps
module tb;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg stop = 1'b0;
  reg [1:0] pins = 2'h0;
  reg port_out = 1'b0;
  wire [7:0] addr, wdata, rdata;
  wire wr, rd, pin, cap, tmo, atmo;
  reg [7:0] v;
  integer miscompares = 0;
  integer checks = 0;
  integer caps = 0;
  integer n;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) caps <= caps + (cap === 1'b1 ? 1 : 0);
  dct_core_model dct_core_model_inst (.clk_i(clk_i), .rdata_i(rdata),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  dct_counter_pair dct_counter_pair_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .stop_recover_i(stop), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .capture_input_pin_a_i(pins[0]), .capture_input_pin_b_i(pins[1]),
    .port_out_i(port_out), .reg_rdata_o(rdata),
    .counter_b_output_pin_o(pin), .capture_irq_o(cap),
    .timeout_irq_o(tmo), .counter_a_timeout_o(atmo));
  task finish_test;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  task chk(input string nm, input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task w(input [7:0] a, input [7:0] d);
    dct_core_model_inst.wr(a, d);
  endtask
  task rc(input [7:0] a, input [7:0] e);
    begin
      dct_core_model_inst.rd(a, v);
      chk($sformatf("reg %h", a), v, e);
    end
  endtask
  // Drives k pulses on pins, each level held wd + 1 cycles, counts captures
  task pulse(input [1:0] p, input integer k, input integer wd,
    input integer e);
    integer i;
    integer c;
    begin
      c = caps;
      for (i = 0; i < 2 * k; i = i + 1) begin
        @(posedge clk_i);
        pins <= i[0] ? 2'h0 : p;
        repeat (wd) @(posedge clk_i);
      end
      repeat (20) @(posedge clk_i);
      chk("captures", 8'(caps - c), 8'(e));
    end
  endtask
  task t_regs;
    begin
      rc(8'h03, 8'h1f);
      w(8'h03, 8'hff);
      rc(8'h03, 8'hff);
      w(8'h03, 8'h20);
      rc(8'h03, 8'h3f);
      w(8'h03, 8'he0);
      @(posedge clk_i);
      stop <= 1'b1;
      @(posedge clk_i);
      stop <= 1'b0;
      rc(8'h03, 8'h3f);
    end
  endtask
  task t_route;
    begin
      w(8'h02, 8'h00);
      for (n = 1; n >= 0; n = n - 1) begin
        @(posedge clk_i);
        port_out <= n[0];
        repeat (3) @(posedge clk_i);
        #1 chk("pin", {7'h00, pin}, {7'h00, n[0]});
      end
    end
  endtask
  task t_edges;
    begin
      w(8'h02, 8'h84);
      w(8'h03, 8'h80);
      for (n = 0; n < 3; n = n + 1) begin
        w(8'h01, 8'h54 + 8'(n * 16));
        pulse(2'h1, 3, 12, n == 2 ? 6 : 3);
      end
      // Both edges, 13 cycles apart: 12 ticks since the last reload
      rc(8'h04, 8'hf3);
      rc(8'h05, 8'hff);
      // Divide by 2 gives exactly 6 ticks over the same 12 cycles
      w(8'h02, 8'h8c);
      pulse(2'h1, 3, 12, 6);
      rc(8'h04, 8'hf9);
      w(8'h01, 8'h5c);
      pulse(2'h1, 1, 3, 0);
      w(8'h02, 8'hc4);
      w(8'h01, 8'hd0);
      pulse(2'h2, 3, 12, 1);
    end
  endtask
  // Sync on: counter A reloads with the capture, so its timeout output
  // rises a fixed 256 cycles after the capture interrupt
  task t_sync;
    begin
      w(8'h02, 8'h84);
      w(8'h01, 8'h54);
      w(8'h03, 8'he0);
      rc(8'h03, 8'hff);
      @(posedge clk_i);
      pins <= 2'h1;
      for (n = 0; n < 40 && cap !== 1'b1; n = n + 1) begin
        @(posedge clk_i);
        #1;
      end
      for (n = 0; n < 300 && (n == 0 || atmo !== 1'b1); n = n + 1) begin
        @(posedge clk_i);
        #1;
      end
      chk("a timeout", n[15:0], 16'd256);
      @(posedge clk_i);
      pins <= 2'h0;
    end
  endtask
  task t_timeout;
    begin
      w(8'h02, 8'h83);
      port_out <= 1'b1;
      for (n = 0; n < 70000 && tmo !== 1'b1; n = n + 1) begin
        @(posedge clk_i);
        #1;
      end
      chk("timeout", {7'h00, tmo}, 8'h01);
      if (tmo !== 1'b1) finish_test;
      // Pin shows the waveform one cycle after it toggles
      chk("pin wave", {7'h00, pin}, 8'h00);
      rc(8'h02, 8'ha3);
      chk("pin wave", {7'h00, pin}, 8'h01);
      w(8'h02, 8'ha3);
      rc(8'h02, 8'h83);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_route;
    t_edges;
    t_sync;
    t_timeout;
    finish_test;
  end
endmodule // tb
